// ### core/smc_ctrl.sv
// Static memory controller core: strobe timing and automatic idle cycles
`timescale 1ns/10ps
`include "smc_defs.svh"
// How it works
// - Setup field: 128 times top bit plus rest.
// - Pulse field: 256 times top bit plus rest.
// - Cycle field: 256 times top two plus rest.
// - Setup, pulse, cycle words per chip select.
// - Strobe-controlled zero write hold holds address, selects.
// - Idle cycle between different chip selects.
// - Chip-select idle drives all controls high.
// - Early read only write-then-read, same select.
// - Early read: zero write hold, zero read setup.
// - Select-controlled write: early read on zero hold.
// - Strobe feedback still low adds early read.
// - Mode write causes reload idle cycle.
// - Reload merges into chip-select idle cycle.
// - Slow clock change also causes reload.
// - Read then write adds one more idle.
// - Data float count after reads, 0 to 15.
// - Internal accesses never wait for data float.
// - Float starts at controlling read strobe rise.
// - Optimised float overlaps next access setup.
// - Unoptimised float counts through read hold.
// - Read mode picks data sampling edge.
module smc_ctrl (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [2:0] req_cs,
	input wire logic [25:0] req_addr,
	input wire logic [31:0] req_wdata,
	input wire logic [3:0] req_be,
	output logic req_ready,
	output logic rd_valid,
	output logic [31:0] rd_data,
	output logic acc_done,
	input wire logic int_req,
	output logic int_ack,
	input wire logic cfg_wr,
	input wire logic [2:0] cfg_cs,
	input wire logic [1:0] cfg_sel,
	input wire logic [31:0] cfg_wdata,
	input wire logic slow_clk_mode,
	output logic reload_pend,
	output logic [25:0] mem_addr,
	output logic [31:0] mem_dout,
	output logic mem_dout_oe,
	input wire logic [31:0] mem_din,
	output logic [7:0] chip_select_n,
	output logic read_strobe_n,
	output logic write_strobe_n,
	input wire logic write_strobe_fb_n,
	output logic [3:0] byte_write_strobe_n,
	output logic [3:0] byte_select_n
);
	import smc_pkg::*;

	smc_tim_if tim ();
	smc_tim_dec u_dec (.t(tim));

	logic [31:0] u_setup_ff [`SMC_NCS];
	logic [31:0] u_pulse_ff [`SMC_NCS];
	logic [31:0] u_cycle_ff [`SMC_NCS];
	logic [31:0] u_mode_ff [`SMC_NCS];
	logic [31:0] a_setup_ff [`SMC_NCS];
	logic [31:0] a_pulse_ff [`SMC_NCS];
	logic [31:0] a_cycle_ff [`SMC_NCS];
	logic [31:0] a_mode_ff [`SMC_NCS];

	smc_state_t state_ff, nxt_state;
	smc_cyc_t cnt_ff;
	logic [3:0] tdf_ff;
	logic acc_wr_ff;
	logic [2:0] acc_cs_ff;
	logic [25:0] acc_addr_ff;
	logic [31:0] acc_wdata_ff;
	logic [3:0] acc_be_ff;
	logic need_cs_ff, need_rl_ff, need_rw_ff, need_er_ff, er_hold_ff;
	logic have_last_ff, last_rd_ff, last_wr_mode_ff, last_tdf_mode_ff;
	logic last_hold0_ff, last_cs_hold0_ff;
	logic [2:0] last_cs_ff;
	logic slow_ff, rl_pend_ff;
	logic fb_s1_ff, fb_s2_ff;
	logic er_fb_late_ff;
	logic [31:0] din_s1w_ff, din_s2_ff;
	logic [2:0] cap_pipe_ff;

	// Window test: is cnt inside [s, s+p)
	function automatic logic in_win(input smc_cyc_t c, input smc_cyc_t s, input smc_cyc_t p);
		in_win = ({1'b0, c} >= {1'b0, s}) && ({1'b0, c} < ({1'b0, s} + {1'b0, p}));
	endfunction

	// Zero hold when setup plus pulse fills the whole cycle
	function automatic logic hold0(input smc_cyc_t s, input smc_cyc_t p, input smc_cyc_t cy);
		hold0 = ({1'b0, s} + {1'b0, p}) == {1'b0, cy};
	endfunction

	logic [31:0] cur_mode;
	logic rd_mode, wr_mode;
	smc_cyc_t cyc_len, ctl_end, nxt_setup;
	logic last_cyc, blk_next, gap_any, post_end, cnt_run, wr_fb_need;
	logic [3:0] tdf_dec;

	assign tim.setup_raw = a_setup_ff[acc_cs_ff];
	assign tim.pulse_raw = a_pulse_ff[acc_cs_ff];
	assign tim.cycle_raw = a_cycle_ff[acc_cs_ff];
	assign cur_mode = a_mode_ff[acc_cs_ff];
	assign rd_mode = cur_mode[`SMC_M_RDMODE];
	assign wr_mode = cur_mode[`SMC_M_WRMODE];
	assign cyc_len = acc_wr_ff ? tim.wcyc : tim.rcyc;
	assign last_cyc = (cnt_ff == cyc_len - 10'h001);
	// Last low cycle of the controlling read strobe
	assign ctl_end = rd_mode ? (tim.rs + tim.rp - 10'h001) : (tim.crs + tim.crp - 10'h001);
	assign nxt_setup = acc_wr_ff ? (wr_mode ? tim.ws : tim.cws) : (rd_mode ? tim.rs : tim.crs);
	assign tdf_dec = tdf_ff - {3'h0, tdf_ff != 4'h0};
	assign post_end = (cnt_ff == `SMC_FB_LOOK);
	assign cnt_run = (state_ff == ST_ACC && !last_cyc) || (state_ff == ST_POST && !post_end);
	// Zero-hold strobe write: one hold cycle, then wait out the feedback synchroniser
	assign wr_fb_need = acc_wr_ff && wr_mode && hold0(tim.ws, tim.wp, tim.wcyc);

	// Float blocks only a read to another select or any write
	always_comb begin
		blk_next = 1'b0;
		if (last_rd_ff && (acc_wr_ff || acc_cs_ff != last_cs_ff)) begin
			if (last_tdf_mode_ff)
				blk_next = {6'h00, tdf_dec} > nxt_setup;
			else
				blk_next = tdf_dec != 4'h0;
		end
	end

	// Each owed idle cycle takes a wait cycle of its own
	assign gap_any = need_cs_ff | need_rl_ff | need_rw_ff | need_er_ff;

	// Pin inputs cross into the clock domain through two flops
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			din_s1w_ff <= 32'h00000000;
			din_s2_ff <= 32'h00000000;
			fb_s1_ff <= 1'b1;
			fb_s2_ff <= 1'b1;
		end else begin
			din_s1w_ff <= mem_din;
			din_s2_ff <= din_s1w_ff;
			fb_s1_ff <= write_strobe_fb_n;
			fb_s2_ff <= fb_s1_ff;
		end
	end

	// User copies take writes; active copies are loaded at reload
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			for (int i = 0; i < `SMC_NCS; i++) begin
				u_setup_ff[i] <= `SMC_RST_SETUP;
				u_pulse_ff[i] <= `SMC_RST_PULSE;
				u_cycle_ff[i] <= `SMC_RST_CYCLE;
				u_mode_ff[i] <= `SMC_RST_MODE;
			end
		end else if (cfg_wr) begin
			unique case (cfg_sel)
				`SMC_SEL_SETUP: u_setup_ff[cfg_cs] <= cfg_wdata;
				`SMC_SEL_PULSE: u_pulse_ff[cfg_cs] <= cfg_wdata;
				`SMC_SEL_CYCLE: u_cycle_ff[cfg_cs] <= cfg_wdata;
				`SMC_SEL_MODE: u_mode_ff[cfg_cs] <= cfg_wdata;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			for (int i = 0; i < `SMC_NCS; i++) begin
				a_setup_ff[i] <= `SMC_RST_SETUP;
				a_pulse_ff[i] <= `SMC_RST_PULSE;
				a_cycle_ff[i] <= `SMC_RST_CYCLE;
				a_mode_ff[i] <= `SMC_RST_MODE;
			end
		end else if (state_ff == ST_WAIT && (need_cs_ff | need_rl_ff)) begin
			// New set applies from the next access on
			for (int i = 0; i < `SMC_NCS; i++) begin
				a_setup_ff[i] <= u_setup_ff[i];
				a_pulse_ff[i] <= u_pulse_ff[i];
				a_cycle_ff[i] <= u_cycle_ff[i];
				a_mode_ff[i] <= u_mode_ff[i];
			end
		end
	end

	// Mode write or slow clock change arms a reload; set beats clear
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			slow_ff <= 1'b0;
			rl_pend_ff <= 1'b0;
		end else begin
			slow_ff <= slow_clk_mode;
			if ((cfg_wr && cfg_sel == `SMC_SEL_MODE) || slow_ff != slow_clk_mode)
				rl_pend_ff <= 1'b1;
			else if (state_ff == ST_IDLE && req_valid && req_ready)
				rl_pend_ff <= 1'b0;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (req_valid && req_ready)
					nxt_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (!gap_any && !blk_next)
					nxt_state = ST_ACC;
			end
			ST_ACC: begin
				if (last_cyc)
					nxt_state = wr_fb_need ? ST_POST : ST_IDLE;
			end
			ST_POST: begin
				if (post_end)
					nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Idle cycle bookkeeping for the accepted request
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			need_cs_ff <= 1'b0;
			need_rl_ff <= 1'b0;
			need_rw_ff <= 1'b0;
			need_er_ff <= 1'b0;
			er_hold_ff <= 1'b0;
		end else if (state_ff == ST_IDLE && req_valid && req_ready) begin
			need_cs_ff <= have_last_ff && req_cs != last_cs_ff;
			// Reload folds into the select change
			need_rl_ff <= rl_pend_ff && !(have_last_ff && req_cs != last_cs_ff);
			need_rw_ff <= have_last_ff && last_rd_ff && req_write;
			need_er_ff <= 1'b0;
			er_hold_ff <= 1'b0;
			// Early read only on the same select after a write
			if (have_last_ff && !last_rd_ff && !req_write && req_cs == last_cs_ff) begin
				if (last_hold0_ff && (a_mode_ff[req_cs][`SMC_M_RDMODE] ?
					a_setup_ff[req_cs][`SMC_F_RD +: 6] == 6'h00 :
					a_setup_ff[req_cs][`SMC_F_CSRD +: 6] == 6'h00))
					need_er_ff <= 1'b1;
				if (!last_wr_mode_ff && last_cs_hold0_ff &&
					a_setup_ff[req_cs][`SMC_F_CSRD +: 6] == 6'h00)
					need_er_ff <= 1'b1;
				if (er_fb_late_ff) begin
					need_er_ff <= 1'b1;
					er_hold_ff <= 1'b1;
				end
			end
		end else if (state_ff == ST_WAIT) begin
			if (need_cs_ff | need_rl_ff) begin
				need_cs_ff <= 1'b0;
				need_rl_ff <= 1'b0;
			end else if (need_rw_ff)
				need_rw_ff <= 1'b0;
			else if (need_er_ff) begin
				need_er_ff <= 1'b0;
				er_hold_ff <= 1'b0;
			end
		end
	end

	// Feedback of the cycle after the strobe rise, seen through the synchroniser
	always_ff @(posedge ref_clk) begin
		if (srst)
			er_fb_late_ff <= 1'b0;
		else if (state_ff == ST_POST && post_end)
			er_fb_late_ff <= !fb_s2_ff;
		else if (state_ff == ST_ACC)
			er_fb_late_ff <= 1'b0;
	end

	// Request capture and access counter
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			acc_wr_ff <= 1'b0;
			acc_cs_ff <= 3'h0;
			acc_addr_ff <= 26'h0000000;
			acc_wdata_ff <= 32'h00000000;
			acc_be_ff <= 4'h0;
			cnt_ff <= 10'h000;
		end else begin
			if (state_ff == ST_IDLE && req_valid && req_ready) begin
				acc_wr_ff <= req_write;
				acc_cs_ff <= req_cs;
				acc_addr_ff <= req_addr;
				acc_wdata_ff <= req_wdata;
				acc_be_ff <= req_be;
			end
			cnt_ff <= cnt_run ? cnt_ff + 10'h001 : 10'h000;
		end
	end

	// History of the previous external access
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			have_last_ff <= 1'b0;
			last_rd_ff <= 1'b0;
			last_cs_ff <= 3'h0;
			last_wr_mode_ff <= 1'b0;
			last_tdf_mode_ff <= 1'b0;
			last_hold0_ff <= 1'b0;
			last_cs_hold0_ff <= 1'b0;
		end else if (state_ff == ST_ACC && last_cyc) begin
			have_last_ff <= 1'b1;
			last_rd_ff <= !acc_wr_ff;
			last_cs_ff <= acc_cs_ff;
			last_wr_mode_ff <= wr_mode;
			last_tdf_mode_ff <= cur_mode[`SMC_M_TDFMODE];
			last_hold0_ff <= acc_wr_ff && (wr_mode ? hold0(tim.ws, tim.wp, tim.wcyc) :
				hold0(tim.cws, tim.cwp, tim.wcyc));
			last_cs_hold0_ff <= acc_wr_ff && hold0(tim.cws, tim.cwp, tim.wcyc);
		end
	end

	// Float count loads as the controlling read strobe rises
	always_ff @(posedge ref_clk) begin
		if (srst)
			tdf_ff <= 4'h0;
		else if (state_ff == ST_ACC && !acc_wr_ff && cnt_ff == ctl_end)
			tdf_ff <= cur_mode[`SMC_M_TDF_LSB +: 4];
		else
			tdf_ff <= tdf_dec;
	end

	// Read data sampling, aligned to the synchroniser delay
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cap_pipe_ff <= 3'h0;
			rd_valid <= 1'b0;
			rd_data <= 32'h00000000;
		end else begin
			cap_pipe_ff <= {cap_pipe_ff[1:0], state_ff == ST_ACC && !acc_wr_ff && cnt_ff == ctl_end};
			rd_valid <= cap_pipe_ff[2];
			if (cap_pipe_ff[2])
				rd_data <= din_s2_ff;
		end
	end

	// Internal accesses bypass the float wait entirely
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			int_ack <= 1'b0;
			req_ready <= 1'b0;
			acc_done <= 1'b0;
			reload_pend <= 1'b0;
		end else begin
			int_ack <= int_req;
			req_ready <= nxt_state == ST_IDLE;
			acc_done <= state_ff == ST_ACC && last_cyc;
			reload_pend <= rl_pend_ff;
		end
	end

	// Pin waveforms, registered one cycle behind the state
	logic nx_rd, nx_we, nx_cs, nx_oe, nx_keep;
	always_comb begin
		nx_rd = 1'b0;
		nx_we = 1'b0;
		nx_cs = 1'b0;
		nx_oe = 1'b0;
		nx_keep = 1'b0;
		if (state_ff == ST_ACC) begin
			if (acc_wr_ff) begin
				nx_we = in_win(cnt_ff, tim.ws, tim.wp);
				nx_cs = in_win(cnt_ff, tim.cws, tim.cwp);
				nx_oe = cnt_ff >= (wr_mode ? tim.ws : tim.cws);
			end else begin
				nx_rd = in_win(cnt_ff, tim.rs, tim.rp);
				nx_cs = in_win(cnt_ff, tim.crs, tim.crp);
			end
			nx_keep = 1'b1;
		end else if (state_ff == ST_POST && cnt_ff == 10'h000)
			nx_keep = 1'b1;
		else if (state_ff == ST_WAIT && er_hold_ff && !(need_cs_ff | need_rl_ff | need_rw_ff))
			nx_keep = 1'b1;
	end

	// Outside an access every control line is high, except the select and byte selects that nx_keep holds
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mem_addr <= 26'h0000000;
			mem_dout <= 32'h00000000;
			mem_dout_oe <= 1'b0;
			chip_select_n <= 8'hff;
			read_strobe_n <= 1'b1;
			write_strobe_n <= 1'b1;
			byte_write_strobe_n <= 4'hf;
			byte_select_n <= 4'hf;
		end else begin
			mem_addr <= acc_addr_ff;
			mem_dout <= acc_wdata_ff;
			mem_dout_oe <= nx_oe || (nx_keep && state_ff != ST_ACC && acc_wr_ff);
			read_strobe_n <= !nx_rd;
			write_strobe_n <= !nx_we;
			byte_write_strobe_n <= nx_we ? ~acc_be_ff : 4'hf;
			byte_select_n <= nx_keep ? ~acc_be_ff : 4'hf;
			chip_select_n <= (nx_cs || (nx_keep && state_ff != ST_ACC)) ?
				~(8'h01 << acc_cs_ff) : 8'hff;
		end
	end
endmodule

// ### core/smc_tim_dec.sv
// Decoder from coded timing fields to effective cycle counts
`timescale 1ns/10ps
`include "smc_defs.svh"
module smc_tim_dec (
	smc_tim_if.dec t
);
	import smc_pkg::*;

	function automatic smc_cyc_t dec_setup(input logic [5:0] f);
		dec_setup = (f[5] ? `SETUP_TIMING_REG_W : 10'h000) + {5'h00, f[4:0]};
	endfunction

	function automatic smc_cyc_t dec_pulse(input logic [6:0] f);
		dec_pulse = (f[6] ? `PULSE_TIMING_REG_W : 10'h000) + {4'h0, f[5:0]};
	endfunction

	function automatic smc_cyc_t dec_cycle(input logic [8:0] f);
		dec_cycle = {f[8:7], `CYCLE_TIMING_REG_W} + {3'h0, f[6:0]};
	endfunction

	// One word per kind, four strobes per setup and pulse word, read and write lengths in the cycle word
	assign t.ws = dec_setup(t.setup_raw[`SMC_F_WR +: 6]);
	assign t.cws = dec_setup(t.setup_raw[`SMC_F_CSWR +: 6]);
	assign t.rs = dec_setup(t.setup_raw[`SMC_F_RD +: 6]);
	assign t.crs = dec_setup(t.setup_raw[`SMC_F_CSRD +: 6]);
	assign t.wp = dec_pulse(t.pulse_raw[`SMC_F_WR +: 7]);
	assign t.cwp = dec_pulse(t.pulse_raw[`SMC_F_CSWR +: 7]);
	assign t.rp = dec_pulse(t.pulse_raw[`SMC_F_RD +: 7]);
	assign t.crp = dec_pulse(t.pulse_raw[`SMC_F_CSRD +: 7]);
	assign t.rcyc = dec_cycle(t.cycle_raw[`SMC_F_CYC_RD +: 9]);
	assign t.wcyc = dec_cycle(t.cycle_raw[`SMC_F_CYC_WR +: 9]);
endmodule

// ### inc/smc_defs.svh
// Constants of the static memory timing and idle cycle controller
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH
`define SMC_NCS 8
`define SMC_SEL_SETUP 2'h0
`define SMC_SEL_PULSE 2'h1
`define SMC_SEL_CYCLE 2'h2
`define SMC_SEL_MODE 2'h3
`define SMC_F_WR 0
`define SMC_F_CSWR 8
`define SMC_F_RD 16
`define SMC_F_CSRD 24
`define SMC_F_CYC_RD 0
`define SMC_F_CYC_WR 16
`define SMC_M_RDMODE 0
`define SMC_M_WRMODE 1
`define SMC_M_TDF_LSB 16
`define SMC_M_TDFMODE 20
`define SETUP_TIMING_REG_W 10'h080
`define PULSE_TIMING_REG_W 10'h100
`define CYCLE_TIMING_REG_W 8'h00
`define SMC_FB_LOOK 10'h003
`define SMC_RST_SETUP 32'h01010101
`define SMC_RST_PULSE 32'h01010101
`define SMC_RST_CYCLE 32'h00030003
`define SMC_RST_MODE 32'h00000003
`endif

// ### inc/smc_pkg.sv
// Types of the static memory timing and idle cycle controller
package smc_pkg;
	typedef logic [9:0] smc_cyc_t;
	typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_ACC, ST_POST} smc_state_t;
endpackage

// ### inc/smc_tim_if.sv
// Raw timing words of one chip select and their decoded cycle counts
`timescale 1ns/10ps
interface smc_tim_if;
	logic [31:0] setup_raw;
	logic [31:0] pulse_raw;
	logic [31:0] cycle_raw;
	smc_pkg::smc_cyc_t rs, crs, ws, cws;
	smc_pkg::smc_cyc_t rp, crp, wp, cwp;
	smc_pkg::smc_cyc_t rcyc, wcyc;
	modport dec (input setup_raw, pulse_raw, cycle_raw,
		output rs, crs, ws, cws, rp, crp, wp, cwp, rcyc, wcyc);
	modport usr (output setup_raw, pulse_raw, cycle_raw,
		input rs, crs, ws, cws, rp, crp, wp, cwp, rcyc, wcyc);
endinterface

// ### sim/smc_ctrl_props.sv
// Pin-level assertions for the static memory controller
`timescale 1ns/10ps
`include "smc_defs.svh"
module smc_ctrl_chk (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic int_req,
	input wire logic int_ack,
	input wire logic cfg_wr,
	input wire logic [1:0] cfg_sel,
	input wire logic slow_clk_mode,
	input wire logic reload_pend,
	input wire logic [25:0] mem_addr,
	input wire logic mem_dout_oe,
	input wire logic [7:0] chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [3:0] byte_write_strobe_n,
	input wire logic [3:0] byte_select_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	logic [7:0] last_cs_ff;
	logic gap_ff;
	logic quiet;
	assign quiet = &{chip_select_n, read_strobe_n, byte_select_n, byte_write_strobe_n};
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			last_cs_ff <= 8'hff;
			gap_ff <= 1'b1;
		end else if (chip_select_n != 8'hff) begin
			last_cs_ff <= chip_select_n;
			gap_ff <= 1'b0;
		end else if (quiet) begin
			gap_ff <= 1'b1;
		end
	end
	sequence new_sel;
		chip_select_n != 8'hff && last_cs_ff != 8'hff && chip_select_n != last_cs_ff;
	endsequence
	sequence mode_write;
		cfg_wr && cfg_sel == `SMC_SEL_MODE;
	endsequence
	a_sel_gap_quiet: assert property (new_sel |-> gap_ff)
		else $error("select changed with no quiet cycle");
	a_one_select: assert property ($onehot0(~chip_select_n))
		else $error("two selects active");
	a_rd_then_wr: assert property (!read_strobe_n |=> write_strobe_n && !mem_dout_oe)
		else $error("write right after read");
	a_wr_hold_addr: assert property ($rose(write_strobe_n) |-> $stable(mem_addr) && $stable(byte_select_n))
		else $error("address moved at write strobe rise");
	a_mode_reload: assert property (mode_write |-> ##[1:2] reload_pend)
		else $error("mode write did not arm reload");
	a_slow_reload: assert property ($changed(slow_clk_mode) |-> ##[1:2] reload_pend)
		else $error("slow mode change did not arm reload");
	a_int_no_stall: assert property (int_req |=> int_ack)
		else $error("internal access stalled");
	a_bus_turn: assert property (mem_dout_oe |-> read_strobe_n)
		else $error("data driven during read");
endmodule
bind smc_ctrl smc_ctrl_chk smc_ctrl_chk_i (.ref_clk(ref_clk), .srst(srst), .int_req(int_req),
	.int_ack(int_ack), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .slow_clk_mode(slow_clk_mode),
	.reload_pend(reload_pend), .mem_addr(mem_addr), .mem_dout_oe(mem_dout_oe),
	.chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
	.write_strobe_n(write_strobe_n), .byte_write_strobe_n(byte_write_strobe_n),
	.byte_select_n(byte_select_n));

// ### sim/smc_mem_model.sv
// Behavioural asynchronous memory on the far side of the controller
`timescale 1ns/10ps
module smc_mem_model (
	input wire logic ref_clk,
	input wire logic slow_fb,
	input wire logic [7:0] chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [25:0] mem_addr,
	input wire logic [31:0] mem_dout,
	input wire logic mem_dout_oe,
	output logic [31:0] mem_din,
	output logic write_strobe_fb_n
);
	logic [31:0] mem_ff [0:63];
	logic [31:0] last_ff = 32'h0;
	logic [2:0] fb_dly_ff = 3'h7;
	logic [5:0] idx;
	logic drv;
	always_comb begin
		idx = {3'h0, mem_addr[2:0]};
		for (int i = 0; i < 8; i++)
			if (!chip_select_n[i])
				idx[5:3] = i[2:0];
	end
	// Drives only while selected and read strobe low
	assign drv = !read_strobe_n && chip_select_n != 8'hff;
	// Released bus shows the inverse, so a stale sample cannot match
	assign mem_din = drv ? mem_ff[idx] : ~last_ff;
	// Heavy load: fed-back strobe rises late
	assign write_strobe_fb_n = slow_fb ? &{fb_dly_ff, write_strobe_n} : write_strobe_n;
	always @(posedge ref_clk) begin
		fb_dly_ff <= {fb_dly_ff[1:0], write_strobe_n};
		if (drv)
			last_ff <= mem_ff[idx];
		if (!write_strobe_n && chip_select_n != 8'hff && mem_dout_oe)
			mem_ff[idx] <= mem_dout;
	end
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the static memory controller
`timescale 1ns/10ps
`include "smc_defs.svh"
module tb_top;
	import smc_pkg::*;
	logic ref_clk, srst, req_valid, req_write, int_req, int_prev, cfg_wr, slow_clk_mode, slow_fb;
	logic [2:0] req_cs, cfg_cs;
	logic [1:0] cfg_sel;
	logic [25:0] req_addr, mem_addr;
	logic [31:0] req_wdata, cfg_wdata, rd_data, mem_dout, mem_din;
	logic [3:0] req_be, byte_write_strobe_n, byte_select_n;
	logic req_ready, rd_valid, acc_done, int_ack, reload_pend, mem_dout_oe;
	logic read_strobe_n, write_strobe_n, write_strobe_fb_n;
	logic [7:0] chip_select_n;
	int fail_count = 0, checked = 0, cyc = 0, t_go, t_lo, lo_n, t_dn, t_up, base_s, base_c;
	int gap [3];
	logic [31:0] ref_mem [int];
	smc_ctrl smc_ctrl_i (.ref_clk(ref_clk), .srst(srst), .req_valid(req_valid),
		.req_write(req_write), .req_cs(req_cs), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_be(req_be), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.acc_done(acc_done), .int_req(int_req), .int_ack(int_ack), .cfg_wr(cfg_wr),
		.cfg_cs(cfg_cs), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata), .slow_clk_mode(slow_clk_mode),
		.reload_pend(reload_pend), .mem_addr(mem_addr), .mem_dout(mem_dout),
		.mem_dout_oe(mem_dout_oe), .mem_din(mem_din), .chip_select_n(chip_select_n),
		.read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
		.write_strobe_fb_n(write_strobe_fb_n), .byte_write_strobe_n(byte_write_strobe_n),
		.byte_select_n(byte_select_n));
	smc_mem_model smc_mem_model_i (.ref_clk(ref_clk), .slow_fb(slow_fb),
		.chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
		.write_strobe_n(write_strobe_n), .mem_addr(mem_addr), .mem_dout(mem_dout),
		.mem_dout_oe(mem_dout_oe), .mem_din(mem_din), .write_strobe_fb_n(write_strobe_fb_n));
	function automatic int dec_s(input logic [5:0] v);
		return 128 * v[5] + v[4:0];
	endfunction
	function automatic int dec_p(input logic [6:0] v);
		return 256 * v[6] + v[5:0];
	endfunction
	function automatic int dec_c(input logic [8:0] v);
		return 256 * v[8:7] + v[6:0];
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cfg(input logic [2:0] cs, input logic [1:0] sel, input logic [31:0] d);
		cfg_wr <= 1'b1;
		cfg_cs <= cs;
		cfg_sel <= sel;
		cfg_wdata <= d;
		@(posedge ref_clk);
		cfg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	// One whole access; records strobe timing for the callers
	task automatic access(input logic wr, input logic [2:0] cs, input logic [2:0] a,
		input logic [31:0] d);
		int n;
		logic got, done;
		n = 0;
		got = wr;
		done = 0;
		t_lo = -1;
		lo_n = 0;
		if (wr)
			ref_mem[{cs, a}] = d;
		req_valid <= 1'b1;
		req_write <= wr;
		req_cs <= cs;
		req_addr <= {23'h0, a};
		req_wdata <= d;
		do @(posedge ref_clk); while (req_ready !== 1'b1 && n++ < 2000);
		t_go = cyc;
		req_valid <= 1'b0;
		while (!(got && done) && n++ < 4000) begin
			@(posedge ref_clk);
			if (read_strobe_n === 1'b0) begin
				if (t_lo < 0)
					t_lo = cyc;
				lo_n++;
			end
			if (write_strobe_n === 1'b0)
				t_up = cyc + 1;
			if (acc_done === 1'b1 && !done) begin
				done = 1;
				t_dn = cyc;
			end
			if (rd_valid === 1'b1) begin
				got = 1;
				check(rd_data, ref_mem[{cs, a}], "read data");
			end
		end
		if (n >= 4000)
			check(0, 1, "access hung");
	endtask
	initial begin
		ref_clk = 0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		int_prev <= int_req;
		int_req <= 1'($urandom);
		if (!srst && cyc > 10)
			check(int_ack, int_prev, "internal ack");
	end
	initial begin
		repeat (30000) @(posedge ref_clk);
		fail_count++;
		$display("watchdog expired");
		summarize();
	end
	initial begin
		automatic logic [5:0] su [3] = '{6'h00, 6'h21, 6'h05};
		automatic logic [6:0] pu [3] = '{7'h01, 7'h05, 7'h41};
		automatic logic [8:0] cy [3] = '{9'h003, 9'h186, 9'h10a};
		automatic logic [7:0] rs [3] = '{8'h01, 8'h01, 8'h00};
		void'($urandom(32'ha45c0a35));
		{srst, req_valid, req_write, int_req, int_prev, cfg_wr, slow_clk_mode, slow_fb} = 8'h80;
		{req_cs, cfg_cs, cfg_sel, req_addr, req_wdata, cfg_wdata} = '0;
		req_be = 4'hf;
		repeat (6) @(posedge ref_clk);
		srst <= 1'b0;
		check({chip_select_n, read_strobe_n, write_strobe_n, byte_select_n}, 32'h3fff, "reset");
		$display("test reset done");
		access(1, 0, 1, $urandom);
		for (int k = 0; k < 3; k++) begin
			cfg(0, `SMC_SEL_SETUP, {2'h0, su[k], 2'h0, su[k], 16'h0101});
			cfg(0, `SMC_SEL_PULSE, {1'h0, pu[k], 1'h0, pu[k], 16'h0101});
			cfg(0, `SMC_SEL_CYCLE, {16'h0003, 7'h0, cy[k]});
			cfg(0, `SMC_SEL_MODE, 32'h3);
			access(0, 0, 1, 0);
			if (k == 0) begin
				base_s = t_lo - t_go - dec_s(su[0]);
				base_c = t_dn - t_go - dec_c(cy[0]);
			end
			check(32'(lo_n), 32'(dec_p(pu[k])), "pulse");
			check(32'(t_lo - t_go - dec_s(su[k])), 32'(base_s), "setup");
			check(32'(t_dn - t_go - dec_c(cy[k])), 32'(base_c), "cycle");
		end
		$display("test decode done");
		cfg(1, `SMC_SEL_MODE, 32'h2);
		access(1, 1, 3, $urandom);
		access(0, 1, 3, 0);
		access(0, 0, 1, 0);
		access(1, 1, 4, $urandom);
		access(0, 1, 4, 0);
		$display("test select change done");
		cfg(2, `SMC_SEL_CYCLE, 32'h00020003);
		for (int k = 0; k < 3; k++) begin
			cfg(2, `SMC_SEL_SETUP, {rs[k], rs[k], 16'h0101});
			cfg(2, `SMC_SEL_MODE, 32'h3);
			slow_fb <= (k == 1);
			access(1, 2, 5, $urandom);
			access(0, 2, 5, 0);
			gap[k] = t_lo - t_up;
		end
		check(32'(gap[1] - gap[0]), 32'h1, "feedback early read");
		check(32'(gap[2]), 32'(gap[0]), "zero setup early read");
		$display("test early read done");
		slow_clk_mode <= 1'b1;
		repeat (3) @(posedge ref_clk);
		check(reload_pend, 1'b1, "slow entry reload");
		access(0, 1, 3, 0);
		slow_clk_mode <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check(reload_pend, 1'b1, "slow exit reload");
		$display("test slow mode done");
		summarize();
	end
endmodule
